// ===== verilog/mfs_status.sv
// Freefall/motion source register with latching and interrupt.
// Assumes detector inputs are synchronous to clk (sample logic).
// Operation
// - Event-active bit 7 follows the selected axis combination.
// - Interrupt is raised only when active and enabled, routed by cfg.
// - Unlatched shows live events, latched holds the causing events.
// - The source register at 0x16 is read-only; writes are ignored.
// - Bit 5 is the Z high-event flag, zero when Z disabled.
// - Bit 4 is the Z sign, 1 negative, zero when Z disabled.
// - Bit 3 is the Y high-event flag, zero when Y disabled.
// - Bit 2 is the Y sign, 1 negative, zero when Y disabled.
// - Bit 1 is the X high-event flag, zero when X disabled.
// - Bit 0 is the X sign, 1 negative, zero when X disabled.
// - Latching freezes flags on active, cleared by a source read.
// - Active is AND of low-g flags or OR of high-g flags by select.
// - An axis flag rises only when enabled and under (freefall) or over (motion) threshold.
`timescale 1ns/1ps
`include "mfs_cfg.svh"
module mfs_status (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Detector inputs (threshold compare results)
    input wire logic [2:0] low_flag,
    input wire logic [2:0] high_flag,
    input wire logic [2:0] axis_neg,
    // Configuration
    input wire logic [2:0] axis_en,
    input wire logic motion_sel,
    input wire logic latch_en,
    input wire logic int_enable,
    input wire logic int_route,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output mfs_pkg::mfs_byte_t reg_rdata,
    // Interrupt outputs, one per pin
    output logic int_pin1,
    output logic int_pin2
);
    import mfs_pkg::*;

    mfs_state_t state;
    mfs_state_t next_state;
    logic [7:0] src;
    logic [7:0] next_src;
    logic active_live;

    ////////////////////////////////////////////////////////////////
    // Summary combination
    mfs_combine u_comb (
        .axis_en(axis_en),
        .low_flag(low_flag),
        .high_flag(high_flag),
        .motion_sel(motion_sel),
        .active(active_live)
    );

    ////////////////////////////////////////////////////////////////
    // Live image of the source bits
    // enabled axes only
    wire [2:0] he = axis_en & (motion_sel ? high_flag : low_flag);
    wire [2:0] hp = axis_en & axis_neg & he;
    // Y and X events in bits 3 and 1
    // Y and X signs in bits 2 and 0
    wire [7:0] live_src = {active_live, 1'b0, he[2], hp[2], he[1], hp[1],
                           he[0], hp[0]};
    // drop flags of a disabled axis even while held
    wire [7:0] en_mask = {1'b1, 1'b0, {2{axis_en[2]}}, {2{axis_en[1]}},
                          {2{axis_en[0]}}};
    // reads decode; writes never reach src
    wire src_sel = (reg_addr == `MFS_SRC_ADDR);
    wire src_read = reg_rd & src_sel;

    ////////////////////////////////////////////////////////////////
    // Latch control
    // freeze on active, clear on read; set wins over clear
    // A read in the cycle of a live event keeps the latch and loads
    // the fresh image, so no event is lost to the clear.
    always_comb begin
        next_state = state;
        next_src = src;
        case (state)
            MFS_LIVE: begin
                next_src = live_src;
                if (latch_en && active_live) begin
                    next_state = MFS_HELD;
                end
            end
            MFS_HELD: begin
                next_src = src & en_mask;
                if (!latch_en) begin
                    next_state = MFS_LIVE;
                    next_src = live_src;
                end else if (src_read) begin
                    next_state = active_live ? MFS_HELD : MFS_LIVE;
                    next_src = live_src;
                end
            end
            default: begin
                next_state = MFS_LIVE;
                next_src = `MFS_SRC_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= MFS_LIVE;
            src <= `MFS_SRC_RESET;
        end else begin
            state <= next_state;
            src <= next_src;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data and interrupt
    // Read data is zero outside a source read, so a strobe on
    // another address returns nothing.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            int_pin1 <= 1'b0;
            int_pin2 <= 1'b0;
        end else begin
            reg_rdata <= src_read ? src : 8'h00;
            // gated by enable, routed by cfg bit
            int_pin1 <= src[`MFS_BIT_EA] & int_enable & int_route;
            int_pin2 <= src[`MFS_BIT_EA] & int_enable & ~int_route;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    // Source bits are sampled one cycle after their inputs, the
    // same lag as the register update.
    // live active reaches bit 7
    ea_follow_a: assert property (@(posedge clk) disable iff (rst)
        (!latch_en && $past(!latch_en) && !src_read) |=>
        src[7] == $past(active_live)) else $error("ea not following");
    ff_none_a: assert property (@(posedge clk) disable iff (rst)
        (!motion_sel && axis_en == 3'h0) |-> !active_live)
        else $error("freefall active with no axis");
    int_gate_a: assert property (@(posedge clk) disable iff (rst)
        (int_pin1 | int_pin2) |-> $past(src[7] & int_enable))
        else $error("interrupt without enable");
    // active and enabled raises a pin
    int_raise_a: assert property (@(posedge clk) disable iff (rst)
        $past(src[7] & int_enable) |-> (int_pin1 | int_pin2))
        else $error("interrupt not raised");
    int_route_a: assert property (@(posedge clk) disable iff (rst)
        (int_pin1 |-> $past(int_route)) and
        (int_pin2 |-> !$past(int_route)))
        else $error("interrupt on wrong pin");
    bit6_zero_a: assert property (@(posedge clk) disable iff (rst)
        src[6] == 1'b0) else $error("bit 6 set");
    z_mask_a: assert property (@(posedge clk) disable iff (rst)
        $past(!axis_en[2]) |-> src[5:4] == 2'b00)
        else $error("z bits with z disabled");
    y_mask_a: assert property (@(posedge clk) disable iff (rst)
        $past(!axis_en[1]) |-> src[3:2] == 2'b00)
        else $error("y bits with y disabled");
    x_mask_a: assert property (@(posedge clk) disable iff (rst)
        $past(!axis_en[0]) |-> src[1:0] == 2'b00)
        else $error("x bits with x disabled");
    // sign bit only beside its event
    sign_event_a: assert property (@(posedge clk)
        disable iff (rst)
        (src[4] |-> src[5]) and (src[2] |-> src[3]) and
        (src[0] |-> src[1])) else $error("sign without event");
    live_track_a: assert property (@(posedge clk) disable iff (rst)
        state == MFS_LIVE |=> src == $past(live_src))
        else $error("source not live");
    latch_set_a: assert property (@(posedge clk) disable iff (rst)
        (state == MFS_LIVE && latch_en && active_live) |=>
        (state == MFS_HELD && src[7])) else $error("latch did not set");
    // held flags keep value without read
    latch_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state == MFS_HELD && latch_en && !src_read && axis_en == 3'h7)
        |=> src == $past(src)) else $error("held flags moved");
    // read clears held flags to live image
    read_clear_a: assert property (@(posedge clk) disable iff (rst)
        (state == MFS_HELD && latch_en && src_read) |=>
        src == $past(live_src)) else $error("read did not clear");
    write_ign_a: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && !reg_rd && state == MFS_HELD && latch_en &&
        axis_en == 3'h7) |=> src == $past(src))
        else $error("write changed source");
    rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
        !src_read |=> reg_rdata == 8'h00) else $error("stray read data");
    read_data_a: assert property (@(posedge clk) disable iff (rst)
        src_read |=> reg_rdata == $past(src)) else $error("bad rdata");

    // Main scenarios reached
    latch_c: cover property (@(posedge clk) state == MFS_HELD);
    clear_c: cover property (@(posedge clk)
        state == MFS_HELD && src_read);
    int_c: cover property (@(posedge clk) int_pin1 || int_pin2);
    freefall_c: cover property (@(posedge clk) !motion_sel && src[7]);
    set_win_c: cover property (@(posedge clk)
        state == MFS_HELD && src_read && active_live);
endmodule // mfs_status

// ===== verilog/mfs_cfg.svh
// Constants for the freefall/motion event status block.
// Assumes a byte-wide register port with 8-bit addresses.
`ifndef MFS_CFG_SVH
`define MFS_CFG_SVH
`define MFS_SRC_ADDR 8'h16
`define MFS_SRC_RESET 8'h00
`define MFS_BIT_EA 7
`define MFS_BIT_ZHE 5
`define MFS_BIT_ZHP 4
`define MFS_BIT_YHE 3
`define MFS_BIT_YHP 2
`define MFS_BIT_XHE 1
`define MFS_BIT_XHP 0
`endif

// ===== verilog/mfs_pkg.sv
// Types for the freefall/motion event status block.
// Assumes the constants header is included by users.
package mfs_pkg;
    // Latch state of the source flags
    typedef enum logic [0:0] {
        MFS_LIVE = 1'b0,
        MFS_HELD = 1'b1
    } mfs_state_t;
    typedef logic [7:0] mfs_byte_t;
endpackage

// ===== verilog/mfs_combine.sv
// Combines per-axis flags into the event-active summary.
// Masks the raw per-axis flags with the per-axis enables itself.
`timescale 1ns/1ps
module mfs_combine (
    // Per-axis inputs
    input wire logic [2:0] axis_en,
    input wire logic [2:0] low_flag,
    input wire logic [2:0] high_flag,
    // Mode and result
    input wire logic motion_sel,
    output logic active
);
    // Freefall AND over enabled axes, motion OR
    // combine select
    wire any_en = |axis_en;
    wire ff_all = any_en & (&(low_flag | ~axis_en));
    wire mt_any = |(high_flag & axis_en);
    assign active = motion_sel ? mt_any : ff_all;
endmodule // mfs_combine

// ===== tb/mfs_host.sv
// Host model: byte reads and writes on the source register port.
// Assumes the bench owns clk and calls acc from one process.
`timescale 1ns/1ps
module mfs_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Idle port from time zero
    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // One access; read data sampled mid-cycle after the taking edge
    task automatic acc(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= !w;
        reg_wr <= w;
        reg_wdata <= d;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        @(negedge clk);
        q = reg_rdata;
    endtask
endmodule // mfs_host

// ===== tb/test_motion_freefall_event_status.sv
// Bench for the freefall/motion source register block.
// Assumes mfs_pkg is compiled first and the host model is present.
`timescale 1ns/1ps
`define CHK(n,e,g) begin samples_checked++; if ((g) !== (e)) begin \
    bad_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_motion_freefall_event_status;
    import mfs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] low_flag = 3'h0, high_flag = 3'h0, axis_neg = 3'h0;
    logic [2:0] axis_en = 3'h0;
    logic motion_sel = 1'b0, latch_en = 1'b0;
    logic int_enable = 1'b0, int_route = 1'b0;
    logic [7:0] reg_addr, reg_wdata;
    logic reg_rd, reg_wr, int_pin1, int_pin2;
    mfs_byte_t reg_rdata, q;
    int bad_count = 0, samples_checked = 0;
    ////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;
    mfs_status uut (.clk(clk), .rst(rst), .low_flag(low_flag),
        .high_flag(high_flag), .axis_neg(axis_neg), .axis_en(axis_en),
        .motion_sel(motion_sel), .latch_en(latch_en),
        .int_enable(int_enable), .int_route(int_route),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .int_pin1(int_pin1), .int_pin2(int_pin2));
    mfs_host host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    ////////////////////////////////////////////////////////////////////
    // Detector and mode inputs, then let the flags settle
    task setin(input logic [2:0] lo, hi, ng, en, input logic ms, le);
        @(posedge clk);
        low_flag <= lo;
        high_flag <= hi;
        axis_neg <= ng;
        axis_en <= en;
        motion_sel <= ms;
        latch_en <= le;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task rd_chk(input logic [7:0] e);
        host.acc(1'b0, 8'h16, 8'h00, q);
        `CHK("source", e, q)
    endtask
    task ints(input logic p1, p2);
        `CHK("int_pin1", p1, int_pin1)
        `CHK("int_pin2", p2, int_pin2)
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        rd_chk(8'h00);
        ints(1'b0, 1'b0);
    endtask
    task t_motion;
        @(posedge clk);
        int_enable <= 1'b1;
        int_route <= 1'b1;
        setin(3'b000, 3'b101, 3'b100, 3'b111, 1'b1, 1'b0);
        ints(1'b1, 1'b0);
        rd_chk(8'hb2);
        host.acc(1'b1, 8'h16, 8'hff, q);
        rd_chk(8'hb2);
    endtask
    task t_axis_off;
        @(posedge clk);
        int_route <= 1'b0;
        setin(3'b000, 3'b111, 3'b111, 3'b010, 1'b1, 1'b0);
        ints(1'b0, 1'b1);
        rd_chk(8'h8c);
    endtask
    task t_freefall;
        @(posedge clk);
        int_enable <= 1'b0;
        setin(3'b111, 3'b000, 3'b000, 3'b111, 1'b0, 1'b0);
        ints(1'b0, 1'b0);
        rd_chk(8'haa);
        setin(3'b011, 3'b111, 3'b000, 3'b111, 1'b0, 1'b0);
        rd_chk(8'h0a);
    endtask
    task t_latch;
        setin(3'b000, 3'b001, 3'b001, 3'b111, 1'b1, 1'b1);
        setin(3'b000, 3'b000, 3'b001, 3'b111, 1'b1, 1'b1);
        rd_chk(8'h83);
        rd_chk(8'h00);
    endtask
    // Read during a live event, axis masking while held, other address
    task t_held;
        @(posedge clk);
        int_enable <= 1'b1;
        int_route <= 1'b1;
        setin(3'b000, 3'b110, 3'b110, 3'b111, 1'b1, 1'b1);
        ints(1'b1, 1'b0);
        rd_chk(8'hbc);
        setin(3'b000, 3'b000, 3'b110, 3'b011, 1'b1, 1'b1);
        ints(1'b1, 1'b0);
        host.acc(1'b0, 8'h15, 8'h00, q);
        `CHK("other", 8'h00, q)
        rd_chk(8'h8c);
        rd_chk(8'h00);
    endtask
    // Reset in mid-run clears a held source
    task t_rst_mid;
        setin(3'b000, 3'b001, 3'b000, 3'b011, 1'b1, 1'b1);
        setin(3'b000, 3'b000, 3'b000, 3'b011, 1'b1, 1'b1);
        ints(1'b1, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        ints(1'b0, 1'b0);
        rd_chk(8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_motion();
        t_axis_off();
        t_freefall();
        t_latch();
        t_held();
        t_rst_mid();
        results();
    end
endmodule // test_motion_freefall_event_status
